/* dscgb_cfg.svh */
// Purpose: Constants of the deep-sleep clock gate bank.
// Assumes: 32-bit AXI4-Lite register window, 12-bit byte address.
// Notes: Gate registers share one bit layout; reserved bits read zero.
// Overview of operation
// - Each writable bit enables one unit's clock.
// - One clocks the unit, zero stops it.
// - Access to an unclocked unit gives fault.
// - All gating bits reset to zero.
// - Run, sleep, deep-sleep registers share layout.
// - Low-power registers apply only with auto gating.
// - Bits 25, 24 gate comparators one, zero.
// - Bits 19 to 16 gate timers three..zero.
// - Bits 14,12,5,4,1,0 gate serial units.
// - Reserved bits read zero, software preserves them.
`ifndef DSCGB_CFG_SVH
`define DSCGB_CFG_SVH
`define DSCGB_OFF_RUN_GATE 12'h104
`define DSCGB_OFF_SLEEP_GATE 12'h114
`define DSCGB_OFF_DEEP_GATE 12'h124
`define DSCGB_OFF_RUN_CFG 12'h060
`define DSCGB_OFF_STATUS 12'h130
`define DSCGB_OFF_MASK 12'h134
`define DSCGB_GATE_WMASK 32'h030f5033
`define DSCGB_GATE_RESET 32'h00000000
`define DSCGB_AUTO_GATE_BIT 27
`define DSCGB_RUN_CFG_RESET 1'b0
`define DSCGB_NUM_UNITS 12
`define DSCGB_BIT_CMP_ONE 25
`define DSCGB_BIT_CMP_ZERO 24
`define DSCGB_BIT_TMR_ZERO 16
`define DSCGB_BIT_TWI1 14
`define DSCGB_BIT_TWI0 12
`define DSCGB_BIT_SSER1 5
`define DSCGB_BIT_SSER0 4
`define DSCGB_BIT_ASER1 1
`define DSCGB_BIT_ASER0 0
`define DSCGB_RESP_OKAY 2'h0
`define DSCGB_RESP_SLVERR 2'h2
`endif

/* dscgb_pkg.sv */
// Purpose: Types of the deep-sleep clock gate bank.
// Assumes: Constants come from dscgb_cfg.svh.
// Notes: State codes are one-hot.
`include "dscgb_cfg.svh"
package dscgb_pkg;
    typedef logic [31:0] dscgb_word_t;
    typedef logic [11:0] dscgb_addr_t;
    typedef logic [`DSCGB_NUM_UNITS-1:0] dscgb_units_t;
    typedef enum logic [1:0] {
        DSCGB_W_IDLE = 2'b01,
        DSCGB_W_RESP = 2'b10
    } dscgb_wst_e;
    typedef enum logic [1:0] {
        DSCGB_R_IDLE = 2'b01,
        DSCGB_R_DATA = 2'b10
    } dscgb_rst_e;
    typedef enum logic [2:0] {
        DSCGB_M_RUN = 3'b001,
        DSCGB_M_SLEEP = 3'b010,
        DSCGB_M_DEEP = 3'b100
    } dscgb_mode_e;
endpackage

/* dscgb_unit_gate.sv */
// Purpose: Clock enable and access fault detector for one unit.
// Assumes: access is a one-cycle strobe from the bus fabric.
// Notes: The fault uses the enable currently applied to the unit.
`timescale 1ns/1ps
module dscgb_unit_gate (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic gate_en,
    input wire logic access,
    output logic clk_en_q,
    output logic fault_q
);
    logic clk_en_d;
    logic fault_d;

    always_comb begin
        clk_en_d = gate_en;
        fault_d = access & ~clk_en_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_en_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            clk_en_q <= clk_en_d;
            fault_q <= fault_d;
        end
    end
endmodule // dscgb_unit_gate

/* deep_sleep_clock_gate_bank.sv */
// Purpose: Run, sleep and deep-sleep clock gate registers over AXI4-Lite.
// Assumes: sleep and deep_sleep are levels synchronous to aclk.
// Notes: Unit order is comparators, timers, two-wire, sync, async serial.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dscgb_cfg.svh"
module deep_sleep_clock_gate_bank #(
    parameter int NUM_UNITS = `DSCGB_NUM_UNITS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire dscgb_pkg::dscgb_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire dscgb_pkg::dscgb_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire dscgb_pkg::dscgb_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output dscgb_pkg::dscgb_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep,
    input wire logic deep_sleep,
    input wire logic [NUM_UNITS-1:0] unit_access,
    output logic [NUM_UNITS-1:0] unit_clk_en,
    output logic [NUM_UNITS-1:0] unit_fault,
    output logic irq
);
    import dscgb_pkg::*;

    // Register bit that gates unit number idx.
    function automatic int unit_bit(input int idx);
        case (idx)
            0: unit_bit = `DSCGB_BIT_CMP_ONE;
            1: unit_bit = `DSCGB_BIT_CMP_ZERO;
            2: unit_bit = `DSCGB_BIT_TMR_ZERO + 3;
            3: unit_bit = `DSCGB_BIT_TMR_ZERO + 2;
            4: unit_bit = `DSCGB_BIT_TMR_ZERO + 1;
            5: unit_bit = `DSCGB_BIT_TMR_ZERO;
            6: unit_bit = `DSCGB_BIT_TWI1;
            7: unit_bit = `DSCGB_BIT_TWI0;
            8: unit_bit = `DSCGB_BIT_SSER1;
            9: unit_bit = `DSCGB_BIT_SSER0;
            10: unit_bit = `DSCGB_BIT_ASER1;
            default: unit_bit = `DSCGB_BIT_ASER0;
        endcase
    endfunction

    // One-hot select: run, sleep, deep, run cfg, status, mask.
    function automatic logic [5:0] reg_sel(input dscgb_addr_t a);
        case (a)
            `DSCGB_OFF_RUN_GATE: reg_sel = 6'h01;
            `DSCGB_OFF_SLEEP_GATE: reg_sel = 6'h02;
            `DSCGB_OFF_DEEP_GATE: reg_sel = 6'h04;
            `DSCGB_OFF_RUN_CFG: reg_sel = 6'h08;
            `DSCGB_OFF_STATUS: reg_sel = 6'h10;
            `DSCGB_OFF_MASK: reg_sel = 6'h20;
            default: reg_sel = 6'h00;
        endcase
    endfunction

    // Byte-lane merge limited to the writable gate bits.
    function automatic dscgb_word_t merge(input dscgb_word_t old,
                                          input dscgb_word_t data,
                                          input logic [3:0] strb);
        dscgb_word_t lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lanes = lanes & `DSCGB_GATE_WMASK;
        merge = (old & ~lanes) | (data & lanes);
    endfunction

    dscgb_word_t run_gate_q, run_gate_d;
    dscgb_word_t sleep_gate_q, sleep_gate_d;
    dscgb_word_t deep_gate_q, deep_gate_d;
    dscgb_word_t status_q, status_d;
    dscgb_word_t mask_q, mask_d;
    logic auto_gate_q, auto_gate_d;
    dscgb_wst_e wst_q, wst_d;
    dscgb_rst_e rst_q, rst_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    dscgb_addr_t waddr_q, waddr_d;
    dscgb_word_t wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    dscgb_word_t rdata_q, rdata_d;
    logic irq_q, irq_d;
    dscgb_mode_e mode;
    dscgb_word_t eff_gate;
    dscgb_word_t fault_word;
    logic [5:0] wsel;
    logic [5:0] rsel;
    logic do_write;
    logic [NUM_UNITS-1:0] fault_vec;

    // Power mode and the gate word that applies in it.
    // Deep sleep takes precedence when both mode inputs are high.
    // Without auto gating every mode keeps the run gates applied.
    always_comb begin
        if (deep_sleep) begin
            mode = DSCGB_M_DEEP;
        end else if (sleep) begin
            mode = DSCGB_M_SLEEP;
        end else begin
            mode = DSCGB_M_RUN;
        end
        case (mode)
            DSCGB_M_RUN: eff_gate = run_gate_q;
            DSCGB_M_SLEEP: eff_gate = auto_gate_q ? sleep_gate_q
                                                  : run_gate_q;
            DSCGB_M_DEEP: eff_gate = auto_gate_q ? deep_gate_q
                                                 : run_gate_q;
            default: eff_gate = run_gate_q;
        endcase
    end

    // Each unit registers its own enable, so the applied gate lags a
    // register or mode change by one clock; faults use that value.
    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++) begin : g_unit
            dscgb_unit_gate u_gate (
                .aclk(aclk),
                .aresetn(aresetn),
                .gate_en(eff_gate[unit_bit(g)]),
                .access(unit_access[g]),
                .clk_en_q(unit_clk_en[g]),
                .fault_q(fault_vec[g])
            );
        end
    endgenerate

    // Fault pulses go back onto the register layout, so the status
    // register shares the bit positions of the gate registers.
    always_comb begin
        fault_word = '0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            fault_word[unit_bit(i)] = fault_vec[i];
        end
    end

    // Write channel: address and data taken in either order.
    always_comb begin
        wst_d = wst_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        do_write = 1'b0;
        wsel = reg_sel(waddr_q);
        case (wst_q)
            DSCGB_W_IDLE: begin
                if (s_axi_awvalid && awready_q) begin
                    aw_have_d = 1'b1;
                    waddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q) begin
                    w_have_d = 1'b1;
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                end
                // An unmapped address changes nothing and gets an error.
                if (aw_have_q && w_have_q) begin
                    do_write = 1'b1;
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = (wsel == 6'h00) ? `DSCGB_RESP_SLVERR
                                              : `DSCGB_RESP_OKAY;
                    wst_d = DSCGB_W_RESP;
                end
            end
            DSCGB_W_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wst_d = DSCGB_W_IDLE;
                end
            end
            default: begin
                wst_d = DSCGB_W_IDLE;
                bvalid_d = 1'b0;
            end
        endcase
        // Both readies stay low from the take until the response is
        // accepted, so at most one write is ever under way.
        awready_d = (wst_d == DSCGB_W_IDLE) && !aw_have_d && !do_write;
        wready_d = (wst_d == DSCGB_W_IDLE) && !w_have_d && !do_write;
    end

    // Register file; hardware fault events win over a clearing write.
    always_comb begin
        run_gate_d = run_gate_q;
        sleep_gate_d = sleep_gate_q;
        deep_gate_d = deep_gate_q;
        auto_gate_d = auto_gate_q;
        mask_d = mask_q;
        status_d = status_q;
        if (do_write) begin
            if (wsel[0]) begin
                run_gate_d = merge(run_gate_q, wdata_q, wstrb_q);
            end
            if (wsel[1]) begin
                sleep_gate_d = merge(sleep_gate_q, wdata_q, wstrb_q);
            end
            if (wsel[2]) begin
                deep_gate_d = merge(deep_gate_q, wdata_q, wstrb_q);
            end
            if (wsel[3] && wstrb_q[`DSCGB_AUTO_GATE_BIT/8]) begin
                auto_gate_d = wdata_q[`DSCGB_AUTO_GATE_BIT];
            end
            if (wsel[4]) begin
                status_d = status_q & ~merge('0, wdata_q, wstrb_q);
            end
            if (wsel[5]) begin
                mask_d = merge(mask_q, wdata_q, wstrb_q);
            end
        end
        // A fault in the same cycle as a clearing write keeps its bit,
        // so no event is lost to a write aimed at an older one.
        status_d = status_d | fault_word;
        // The interrupt follows registered status and mask, a clock late.
        irq_d = |(status_q & mask_q);
    end

    // Read channel: data one cycle after the address is taken.
    always_comb begin
        rst_d = rst_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        rsel = reg_sel(s_axi_araddr);
        case (rst_q)
            DSCGB_R_IDLE: begin
                if (s_axi_arvalid && arready_q) begin
                    rvalid_d = 1'b1;
                    rresp_d = (rsel == 6'h00) ? `DSCGB_RESP_SLVERR
                                              : `DSCGB_RESP_OKAY;
                    rdata_d = '0;
                    case (rsel)
                        6'h01: rdata_d = run_gate_q;
                        6'h02: rdata_d = sleep_gate_q;
                        6'h04: rdata_d = deep_gate_q;
                        6'h08: rdata_d[`DSCGB_AUTO_GATE_BIT] = auto_gate_q;
                        6'h10: rdata_d = status_q;
                        6'h20: rdata_d = mask_q;
                        default: rdata_d = '0;
                    endcase
                    rst_d = DSCGB_R_DATA;
                end
            end
            DSCGB_R_DATA: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    rst_d = DSCGB_R_IDLE;
                end
            end
            default: begin
                rvalid_d = 1'b0;
                rst_d = DSCGB_R_IDLE;
            end
        endcase
        // A new address is accepted only once the data has been taken.
        arready_d = (rst_d == DSCGB_R_IDLE) && !(rst_q == DSCGB_R_IDLE &&
                    s_axi_arvalid && arready_q);
    end

    // All registers of the block outside the unit gates; reset leaves every unit unclocked.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_gate_q <= `DSCGB_GATE_RESET;
            sleep_gate_q <= `DSCGB_GATE_RESET;
            deep_gate_q <= `DSCGB_GATE_RESET;
            auto_gate_q <= `DSCGB_RUN_CFG_RESET;
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
            wst_q <= DSCGB_W_IDLE;
            rst_q <= DSCGB_R_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `DSCGB_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `DSCGB_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            run_gate_q <= run_gate_d;
            sleep_gate_q <= sleep_gate_d;
            deep_gate_q <= deep_gate_d;
            auto_gate_q <= auto_gate_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Ports are driven straight from the registers above.
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign unit_fault = fault_vec;
    assign irq = irq_q;
endmodule // deep_sleep_clock_gate_bank

/* dscgb_assertions.sv */
// Purpose: Port checker of the deep-sleep clock gate bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`include "dscgb_cfg.svh"
module dscgb_assertions #(
    parameter int NUM_UNITS = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire dscgb_pkg::dscgb_word_t s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_UNITS-1:0] unit_access,
    input wire logic [NUM_UNITS-1:0] unit_clk_en,
    input wire logic [NUM_UNITS-1:0] unit_fault,
    input wire logic irq
);
    import dscgb_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_fault_on_access: assert property (
        1'b1 |=> unit_fault == $past(unit_access & ~unit_clk_en))
        else $error("fault pulse does not match unclocked access");
    a_reset_all_quiet: assert property (disable iff (1'b0)
        !aresetn |=> unit_clk_en == '0 && !s_axi_bvalid && !irq)
        else $error("outputs not cleared by reset");
    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped before rready");
    a_write_resp_time: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after take");
    a_read_resp_time: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response not one edge after take");
    a_one_write: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    a_reserved_zero: assert property (s_axi_rvalid |->
        (s_axi_rdata & ~(`DSCGB_GATE_WMASK | 32'h08000000)) == 32'h0)
        else $error("reserved read bits not zero");
    c_fault: cover property (unit_fault != '0);
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // dscgb_assertions
bind deep_sleep_clock_gate_bank dscgb_assertions #(
    .NUM_UNITS(NUM_UNITS)
) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .unit_access, .unit_clk_en,
    .unit_fault, .irq
);

/* testbench.sv */
// Purpose: Self-checking bench of the deep-sleep clock gate bank.
// Assumes: AXI4-Lite master, 50 ns clock, synchronous active-low reset.
// Notes: Bus answers are checked against queues of expectations.
`timescale 1ns/1ps
`include "dscgb_cfg.svh"
module testbench;
    import dscgb_pkg::*;
    localparam int BITS[12] = '{25, 24, 19, 18, 17, 16, 14, 12, 5, 4, 1, 0};
    localparam logic [1:0] OK = `DSCGB_RESP_OKAY;
    localparam logic [1:0] ERR = `DSCGB_RESP_SLVERR;
    localparam dscgb_word_t WM = `DSCGB_GATE_WMASK;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, sleep, deep_sleep;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    dscgb_addr_t s_axi_awaddr, s_axi_araddr;
    dscgb_word_t s_axi_wdata, s_axi_rdata;
    dscgb_units_t unit_access, unit_clk_en, unit_fault;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int err_count = 0;
    int n_tests = 0;
    deep_sleep_clock_gate_bank DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep, .deep_sleep, .unit_access,
        .unit_clk_en, .unit_fault, .irq
    );
    function automatic dscgb_units_t units(input dscgb_word_t w);
        for (int i = 0; i < 12; i++) units[i] = w[BITS[i]];
    endfunction
    function automatic dscgb_word_t word(input dscgb_units_t u);
        word = '0;
        for (int i = 0; i < 12; i++) word[BITS[i]] = u[i];
    endfunction
    task automatic check(input string nm, input logic [33:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input dscgb_addr_t a, input dscgb_word_t d,
                      input logic [3:0] s, input logic [1:0] r);
        bit aw_done = 0;
        bit w_done = 0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input dscgb_addr_t a, input dscgb_word_t d,
                      input logic [1:0] r);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        finish_test;
    end
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
    end
    initial begin
        dscgb_word_t g_run, g_slp, g_dp;
        dscgb_units_t acc, exp_en, st;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, sleep, deep_sleep} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        unit_access = '0;
        st = '0;
        void'($urandom(32'hd1ca));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("clk_en", 34'(unit_clk_en), 34'h0);
        rd(`DSCGB_OFF_DEEP_GATE, 32'h0, OK);
        rd(`DSCGB_OFF_RUN_GATE, 32'h0, OK);
        rd(`DSCGB_OFF_SLEEP_GATE, 32'h0, OK);
        wr(`DSCGB_OFF_DEEP_GATE, 32'hffffffff, 4'hf, OK);
        rd(`DSCGB_OFF_DEEP_GATE, WM, OK);
        wr(`DSCGB_OFF_DEEP_GATE, 32'h0, 4'hf, OK);
        wr(`DSCGB_OFF_DEEP_GATE, 32'hffffffff, 4'h1, OK);
        rd(`DSCGB_OFF_DEEP_GATE, 32'h00000033, OK);
        wr(12'h200, $urandom, 4'hf, ERR);
        rd(12'h200, 32'h0, ERR);
        g_run = $urandom;
        g_slp = $urandom;
        g_dp = $urandom;
        wr(`DSCGB_OFF_RUN_GATE, g_run, 4'hf, OK);
        wr(`DSCGB_OFF_SLEEP_GATE, g_slp, 4'hf, OK);
        wr(`DSCGB_OFF_DEEP_GATE, g_dp, 4'hf, OK);
        rd(`DSCGB_OFF_SLEEP_GATE, g_slp & WM, OK);
        for (int m = 0; m < 8; m++) begin
            wr(`DSCGB_OFF_RUN_CFG, {4'h0, m[2], 27'h0}, 4'hf, OK);
            rd(`DSCGB_OFF_RUN_CFG, {4'h0, m[2], 27'h0}, OK);
            sleep <= m[0];
            deep_sleep <= m[1];
            repeat (2) @(posedge aclk);
            exp_en = units(m[1] ? (m[2] ? g_dp : g_run)
                                : (m[0] && m[2] ? g_slp : g_run));
            check("clk_en", 34'(unit_clk_en), 34'(exp_en));
        end
        for (int k = 0; k < 4; k++) begin
            acc = dscgb_units_t'($urandom);
            st = st | (acc & ~exp_en);
            unit_access <= acc;
            @(posedge aclk);
            unit_access <= '0;
            @(posedge aclk);
            check("fault", 34'(unit_fault), 34'(acc & ~exp_en));
        end
        repeat (2) @(posedge aclk);
        rd(`DSCGB_OFF_STATUS, word(st), OK);
        check("irq", 34'(irq), 34'h0);
        wr(`DSCGB_OFF_MASK, 32'hffffffff, 4'hf, OK);
        rd(`DSCGB_OFF_MASK, WM, OK);
        repeat (2) @(posedge aclk);
        check("irq", 34'(irq), 34'(st != '0));
        wr(`DSCGB_OFF_STATUS, word(st), 4'hf, OK);
        repeat (2) @(posedge aclk);
        check("irq", 34'(irq), 34'h0);
        rd(`DSCGB_OFF_STATUS, 32'h0, OK);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("clk_en", 34'(unit_clk_en), 34'h0);
        rd(`DSCGB_OFF_DEEP_GATE, 32'h0, OK);
        repeat (2) @(posedge aclk);
        finish_test;
    end
endmodule // testbench
